// file: cdps_pkg.sv
/*
  Shared constants and carrier types for the carrier detect / power save block.
  Assumes one 50 MHz clock and a synchronous active-high reset.
*/
package cdps_pkg;

  // Four strap settings, lowest pin voltage first
  typedef enum logic [1:0] {
    CDPS_LVL_L = 2'h0,
    CDPS_LVL_R = 2'h1,
    CDPS_LVL_F = 2'h2,
    CDPS_LVL_H = 2'h3
  } cdps_level_t;

  typedef enum logic [1:0] {
    CDPS_ST_SAVE  = 2'h0,
    CDPS_ST_ADAPT = 2'h1,
    CDPS_ST_LOCK  = 2'h2
  } cdps_state_t;

  // Three comparator outputs of one strap pin: above 0.2, 0.5, 0.8 of io_supply_rail
  typedef struct packed {
    logic above_high;
    logic above_mid;
    logic above_low;
  } cdps_cmp_t;

  localparam int CDPS_NUM_STRAPS = 4;
  localparam cdps_level_t CDPS_STRAP_RESET = CDPS_LVL_F;
  localparam logic CDPS_PRESENT_LOW_RESET = 1'b1;

  // Adaptation time limit, in microseconds, and its count at 50 MHz
  localparam int CDPS_CLK_MHZ = 50;
  localparam int CDPS_ADAPT_US = 5000;
  localparam int CDPS_ADAPT_CYCLES = CDPS_ADAPT_US * CDPS_CLK_MHZ;
  localparam int CDPS_CNT_W = 24;

endpackage

// file: cdps_strap_decode.sv
/*
  Decodes one four-level strap pin from its three comparator outputs.
  Assumes comparator levels are synchronous to the clock.
*/
`timescale 1ns/100ps

module cdps_strap_decode (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire cdps_pkg::cdps_cmp_t cmp,
  output cdps_pkg::cdps_level_t level
);

  cdps_pkg::cdps_level_t level_reg;
  cdps_pkg::cdps_level_t level_next;

  // -------------------------------------------------------------
  // Thermometer to level
  // -------------------------------------------------------------
  always_comb begin
    // Inconsistent codes resolve to the highest boundary crossed
    if (cmp.above_high) begin
      level_next = cdps_pkg::CDPS_LVL_H;
    end else if (cmp.above_mid) begin
      level_next = cdps_pkg::CDPS_LVL_F;
    end else if (cmp.above_low) begin
      level_next = cdps_pkg::CDPS_LVL_R;
    end else begin
      level_next = cdps_pkg::CDPS_LVL_L;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      level_reg <= cdps_pkg::CDPS_STRAP_RESET;
    end else if (clk_en) begin
      level_reg <= level_next;
    end
  end

  assign level = level_reg;

endmodule

// file: cdps_top.sv
/*
  Carrier detect sequencing, power save control and strap decoding.
  Assumes the analog carrier comparator and equalizer adapt-done are
  synchronous to the clock; the equalizer obeys its power-down level.
*/
`timescale 1ns/100ps

// Contract
// - Strap pin decodes to four levels
// - Open strap pin decodes as second-highest
// - Carrier starts adaptation; present after done
// - No carrier: equalizer down, present high
// - Enter power save automatically without carrier
// - Leave power save automatically on carrier
module cdps_top #(
  parameter int NUM_STRAPS = cdps_pkg::CDPS_NUM_STRAPS,
  parameter int ADAPT_CYCLES = cdps_pkg::CDPS_ADAPT_CYCLES
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic carrier_above,
  input wire logic adapt_done,
  input wire cdps_pkg::cdps_cmp_t [NUM_STRAPS-1:0] strap_cmp,
  output cdps_pkg::cdps_level_t [NUM_STRAPS-1:0] strap_level,
  output logic carrier_present_low,
  output logic adapt_start,
  output logic eq_power_down,
  output logic power_save,
  output logic adapt_timeout
);

  // -------------------------------------------------------------
  // Strap decoders
  // -------------------------------------------------------------
  for (genvar i = 0; i < NUM_STRAPS; i++) begin : g_strap
    cdps_strap_decode u_dec (
      .clock(clock),
      .sys_rst(sys_rst),
      .clk_en(clk_en),
      .cmp(strap_cmp[i]),
      .level(strap_level[i])
    );
  end

  // -------------------------------------------------------------
  // Carrier sequencer
  // -------------------------------------------------------------
  localparam logic [cdps_pkg::CDPS_CNT_W-1:0] ADAPT_LIMIT =
    cdps_pkg::CDPS_CNT_W'(ADAPT_CYCLES - 1);

  cdps_pkg::cdps_state_t state_reg;
  cdps_pkg::cdps_state_t state_next;
  logic [cdps_pkg::CDPS_CNT_W-1:0] cnt_reg;
  logic [cdps_pkg::CDPS_CNT_W-1:0] cnt_next;
  logic present_low_reg;
  logic present_low_next;
  logic start_reg;
  logic start_next;
  logic pd_reg;
  logic pd_next;
  logic save_reg;
  logic save_next;
  logic tmo_reg;
  logic tmo_next;

  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    start_next = 1'b0;
    tmo_next = 1'b0;
    unique case (state_reg)
      cdps_pkg::CDPS_ST_SAVE: begin
        cnt_next = '0;
        if (carrier_above) begin
          state_next = cdps_pkg::CDPS_ST_ADAPT;
          start_next = 1'b1;
        end
      end
      cdps_pkg::CDPS_ST_ADAPT: begin
        if (!carrier_above) begin
          state_next = cdps_pkg::CDPS_ST_SAVE;
        end else if (adapt_done) begin
          state_next = cdps_pkg::CDPS_ST_LOCK;
        end else if (cnt_reg == ADAPT_LIMIT) begin
          // Overlong adapt is flagged but never forces presence
          tmo_next = 1'b1;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      cdps_pkg::CDPS_ST_LOCK: begin
        if (!carrier_above) begin
          state_next = cdps_pkg::CDPS_ST_SAVE;
        end
      end
      default: begin
        state_next = cdps_pkg::CDPS_ST_SAVE;
      end
    endcase
    // Outputs follow the next state so they land with it
    present_low_next = (state_next != cdps_pkg::CDPS_ST_LOCK);
    pd_next = (state_next == cdps_pkg::CDPS_ST_SAVE);
    save_next = (state_next == cdps_pkg::CDPS_ST_SAVE);
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= cdps_pkg::CDPS_ST_SAVE;
      cnt_reg <= '0;
      present_low_reg <= cdps_pkg::CDPS_PRESENT_LOW_RESET;
      start_reg <= 1'b0;
      pd_reg <= 1'b1;
      save_reg <= 1'b1;
      tmo_reg <= 1'b0;
    end else if (clk_en) begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      present_low_reg <= present_low_next;
      start_reg <= start_next;
      pd_reg <= pd_next;
      save_reg <= save_next;
      tmo_reg <= tmo_next;
    end
  end

  assign carrier_present_low = present_low_reg;
  assign adapt_start = start_reg;
  assign eq_power_down = pd_reg;
  assign power_save = save_reg;
  assign adapt_timeout = tmo_reg;

endmodule

// file: cdps_top_monitor.sv
/* Checker of cdps_top port timing; assumes one clock and a sync reset. */
`timescale 1ns/100ps
module cdps_top_monitor (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic carrier_above,
  input wire logic adapt_done,
  input wire logic carrier_present_low,
  input wire logic adapt_start,
  input wire logic eq_power_down,
  input wire logic power_save
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  adapt_go_a: assert property (clk_en && power_save && carrier_above |=> adapt_start)
    else $error("no start");
  lock_cause_a: assert property ($fell(carrier_present_low) |-> $past(adapt_done))
    else $error("early lock");
  loss_down_a: assert property (clk_en && !carrier_above |=> eq_power_down)
    else $error("eq on");
  loss_flag_a: assert property (clk_en && !carrier_above |=> carrier_present_low)
    else $error("flag low");
  save_in_a: assert property (clk_en && !carrier_above |=> power_save)
    else $error("no save");
  save_out_a: assert property (clk_en && carrier_above |=> !power_save)
    else $error("still save");
  lock_awake_a: assert property (!carrier_present_low |-> !power_save)
    else $error("lock in save");
endmodule
bind cdps_top cdps_top_monitor mon (.*);

// file: cdps_far_model.sv
/* Far side: carrier comparator and adapt loop; inputs set at the falling edge. */
`timescale 1ns/100ps
module cdps_far_model (
  input wire logic clock,
  input wire logic sig_on,
  input wire logic slow,
  input wire logic eq_power_down,
  output logic carrier_above,
  output logic adapt_done
);
  int cnt = 0;
  initial {carrier_above, adapt_done} = 2'h0;
  // Adaptation restarts on power-down
  always @(negedge clock) begin
    carrier_above <= sig_on;
    cnt <= eq_power_down ? 0 : cnt + 1;
    // Slow loop lets the adapt time limit run out
    adapt_done <= !eq_power_down && cnt >= (slow ? 20 : 3);
  end
endmodule

// file: carrier_detect_power_save_tb_top.sv
/* Bench of cdps_top: random stimulus against a cycle model. */
`timescale 1ns/100ps
module carrier_detect_power_save_tb_top;
  logic clock = 1'b0, sys_rst = 1'b1, clk_en = 1'b1, sig_on = 1'b0;
  logic carrier_above, adapt_done, carrier_present_low, adapt_start, eq_power_down, power_save;
  logic adapt_timeout, slow = 1'b0, e_start = 1'b0, e_tmo = 1'b0;
  localparam int ADAPT_N = 8;
  int ac = 0;
  logic [7:0] rnd = 8'h32;
  cdps_pkg::cdps_cmp_t [3:0] strap_cmp = 12'h000;
  cdps_pkg::cdps_level_t [3:0] strap_level;
  int fails = 0, comparisons = 0, st = 0, lv[4] = '{default: 2};
  cdps_top #(.ADAPT_CYCLES(ADAPT_N)) uut (.clock, .sys_rst, .clk_en, .carrier_above, .adapt_done,
    .strap_cmp, .strap_level, .carrier_present_low, .adapt_start, .eq_power_down,
    .power_save, .adapt_timeout);
  cdps_far_model far (.clock, .sig_on, .slow, .eq_power_down, .carrier_above, .adapt_done);
  initial forever #10 clock = ~clock;
  initial #60000 report_and_stop(1); // Two tests of 1004 cycles
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input logic [2:0] got, input logic [2:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: %h not %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop(input int late);
    fails += late;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // State 0 save, 1 adapt, 2 locked
  task automatic cyc(input int t, input logic r);
    @(negedge clock);
    if (clk_en) begin
      e_start = !sys_rst && carrier_above && st == 0;
      e_tmo = !sys_rst && carrier_above && st == 1 && !adapt_done && ac == ADAPT_N - 1;
      ac = sys_rst || st == 0 || e_tmo ? 0 :
        st == 1 && carrier_above && !adapt_done ? ac + 1 : ac;
      st = sys_rst || !carrier_above ? 0 : st < 2 && (st == 0 || adapt_done) ? st + 1 : st;
    end
    // Pulses stand frozen while the clock enable is low
    chk({1'b0, adapt_start, adapt_timeout}, {1'b0, e_start, e_tmo});
    chk({carrier_present_low, power_save, eq_power_down}, {st != 2, st == 0, st == 0});
    for (int i = 0; i < 4; i++) begin
      if (clk_en)
        lv[i] = sys_rst ? 2 : strap_cmp[i][2] ? 3 : strap_cmp[i][1] ? 2 : strap_cmp[i][0];
      chk({1'b0, strap_level[i]}, 3'(lv[i]));
    end
    rnd = lfsr(rnd);
    sys_rst <= r;
    clk_en <= r || t == 0 || rnd[2];
    slow <= t == 1;
    if (rnd[7:5] == 3'h0 && (t == 0 || rnd[4:3] == 2'h0))
      sig_on <= ~sig_on;
    strap_cmp <= {rnd[3:0], lfsr(rnd)};
  endtask
  initial begin
    for (int t = 0; t < 2; t++) begin
      repeat (4) cyc(t, 1'b1);
      repeat (1000) cyc(t, 1'b0);
      $display("test %0d done", t);
    end
    report_and_stop(0);
  end
endmodule
